// *** hdl/bhm_map.svh ***
`ifndef BHM_MAP_SVH
`define BHM_MAP_SVH
`define BHM_PROD_RESET 8'h00
`define BHM_PROD_HI_MSB 15
`define BHM_PROD_HI_LSB 8
`define BHM_PROD_LO_MSB 7
`define BHM_PROD_LO_LSB 0
`define BHM_MUL_LATENCY 1
`define BHM_S8_CYCLES 6
`define BHM_U16_CYCLES 28
`define BHM_S16_CYCLES 40
`endif

// *** hdl/bhm_pkg.sv ***
package bhm_pkg;
    typedef logic [7:0] bhm_byte_t;
    typedef logic [15:0] bhm_prod_t;
endpackage

// *** hdl/bhm_multiplier.sv ***
// Summary of operation
// RL1: both bytes are unsigned and the full 16-bit product splits into high and low bytes.
// RL2: a multiply leaves the carry, zero, overflow, negative and digit carry flags as they were.
// RL3: both product bytes are written at the edge ending the multiply instruction cycle.
// RL4: one operand is the working register, the other the addressed file register byte.
// RL5: software builds 8x8 signed products by subtracting the other operand from the high byte.
// RL6: software builds 16x16 unsigned products from four weighted partial products with carries.
// RL7: software corrects 16x16 signed products by subtracting from the upper result half.
// RL8: software routines stay within 6, 28 and 40 instruction cycles respectively.
// RL9: the product bytes hold until the next multiply or a direct file register write.
`include "bhm_map.svh"
`timescale 1ns/1ps
`default_nettype none
module bhm_multiplier
    import bhm_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // instruction decoder
    input wire logic multiply_working_by_file,
    input wire logic [7:0] working_register,
    input wire logic [7:0] file_operand,
    // alu status flags passing through
    input wire logic [4:0] status_in,
    output logic [4:0] status_out,
    // direct file register writes
    input wire logic prod_hi_write,
    input wire logic prod_lo_write,
    input wire logic [7:0] write_data,
    // product register pair
    output var logic [7:0] product_high_byte,
    output var logic [7:0] product_low_byte
);

    function automatic bhm_prod_t bhm_mul(input bhm_byte_t a, input bhm_byte_t b);
        bhm_mul = 16'(a) * 16'(b);
    endfunction

    // byte selects shared by the checks; both halves always come from one product
    function automatic bhm_byte_t bhm_hi_of(input bhm_byte_t a, input bhm_byte_t b);
        bhm_prod_t p;
        p = bhm_mul(a, b);
        return p[`BHM_PROD_HI_MSB:`BHM_PROD_HI_LSB];
    endfunction

    function automatic bhm_byte_t bhm_lo_of(input bhm_byte_t a, input bhm_byte_t b);
        bhm_prod_t p;
        p = bhm_mul(a, b);
        return p[`BHM_PROD_LO_MSB:`BHM_PROD_LO_LSB];
    endfunction

    bhm_prod_t next_product;
    assign next_product = bhm_mul(working_register, file_operand); // [RL1] [RL4]

    // flags are never touched by the multiplier
    assign status_out = status_in; // [RL2]

    ////////////////////////////////////////////////////////////////////////////
    // product high byte; a multiply outranks a same-cycle direct write
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            product_high_byte <= `BHM_PROD_RESET;
        end else if (multiply_working_by_file) begin
            product_high_byte <= next_product[`BHM_PROD_HI_MSB:`BHM_PROD_HI_LSB]; // [RL1] [RL3]
        end else if (prod_hi_write) begin
            product_high_byte <= write_data; // [RL9]
        end
    end

    // product low byte
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            product_low_byte <= `BHM_PROD_RESET;
        end else if (multiply_working_by_file) begin
            product_low_byte <= next_product[`BHM_PROD_LO_MSB:`BHM_PROD_LO_LSB]; // [RL1] [RL3]
        end else if (prod_lo_write) begin
            product_low_byte <= write_data; // [RL9]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    chk_product_value: assert property (@(posedge sys_clk) disable iff (rst) // [RL1]
        multiply_working_by_file |=> {product_high_byte, product_low_byte} ==
            $past(working_register) * $past(file_operand))
        else $error("product does not match operands");
    chk_flags_kept: assert property (@(posedge sys_clk) disable iff (rst) // [RL2]
        status_out == status_in)
        else $error("multiplier altered status flags");
    chk_one_cycle: assert property (@(posedge sys_clk) disable iff (rst) // [RL3]
        multiply_working_by_file ##1 !multiply_working_by_file && !prod_hi_write
            |=> $stable(product_high_byte))
        else $error("product not ready after one cycle");
    chk_working_operand: assert property (@(posedge sys_clk) disable iff (rst) // [RL4]
        multiply_working_by_file && file_operand == 8'h01
            |=> product_low_byte == $past(working_register) && product_high_byte == 8'h00)
        else $error("working register not used as operand");
    chk_hold_high: assert property (@(posedge sys_clk) disable iff (rst) // [RL9]
        !multiply_working_by_file && !prod_hi_write |=> $stable(product_high_byte))
        else $error("product high changed without cause");
    chk_hold_low: assert property (@(posedge sys_clk) disable iff (rst) // [RL9]
        !multiply_working_by_file && !prod_lo_write |=> $stable(product_low_byte))
        else $error("product low changed without cause");
    chk_write_high: assert property (@(posedge sys_clk) disable iff (rst) // [RL9]
        prod_hi_write && !multiply_working_by_file |=> product_high_byte == $past(write_data))
        else $error("direct write to product high lost");
    chk_write_low: assert property (@(posedge sys_clk) disable iff (rst) // [RL9]
        prod_lo_write && !multiply_working_by_file |=> product_low_byte == $past(write_data))
        else $error("direct write to product low lost");

    cov_multiply: cover property (@(posedge sys_clk) disable iff (rst)
        multiply_working_by_file ##1 multiply_working_by_file);
    cov_max_product: cover property (@(posedge sys_clk) disable iff (rst)
        multiply_working_by_file && working_register == 8'hff && file_operand == 8'hff);
    cov_write_then_mul: cover property (@(posedge sys_clk) disable iff (rst)
        prod_hi_write ##1 multiply_working_by_file);
    cov_collision: cover property (@(posedge sys_clk) disable iff (rst)
        prod_lo_write && multiply_working_by_file);
    cov_signed_operands: cover property (@(posedge sys_clk) disable iff (rst)
        multiply_working_by_file && working_register[7] && file_operand[7]);

    ////////////////////////////////////////////////////////////////////////////
    // byte-wise product checks
    property p_high_value;
        @(posedge sys_clk) disable iff (rst)
        multiply_working_by_file |=> product_high_byte ==
            bhm_hi_of($past(working_register), $past(file_operand));
    endproperty
    chk_high_value: assert property (p_high_value) // [RL1]
        else $error("product high byte wrong");

    property p_low_value;
        @(posedge sys_clk) disable iff (rst)
        multiply_working_by_file |=> product_low_byte ==
            bhm_lo_of($past(working_register), $past(file_operand));
    endproperty
    chk_low_value: assert property (p_low_value) // [RL1]
        else $error("product low byte wrong");

    property p_zero_operand;
        @(posedge sys_clk) disable iff (rst)
        multiply_working_by_file && (working_register == 8'h00 || file_operand == 8'h00)
            |=> product_high_byte == 8'h00 && product_low_byte == 8'h00;
    endproperty
    chk_zero_operand: assert property (p_zero_operand) // [RL1]
        else $error("zero operand gave nonzero product");

    property p_full_scale;
        @(posedge sys_clk) disable iff (rst)
        multiply_working_by_file && working_register == 8'hff && file_operand == 8'hff
            |=> product_high_byte == 8'hfe && product_low_byte == 8'h01;
    endproperty
    chk_full_scale: assert property (p_full_scale) // [RL1]
        else $error("full scale product wrong");

    // a signed multiplier would give ff00 here
    property p_msb_unsigned;
        @(posedge sys_clk) disable iff (rst)
        multiply_working_by_file && working_register == 8'h80 && file_operand == 8'h02
            |=> product_high_byte == 8'h01 && product_low_byte == 8'h00;
    endproperty
    chk_msb_unsigned: assert property (p_msb_unsigned) // [RL1]
        else $error("top operand bit treated as sign");

    property p_flags_on_mul;
        @(posedge sys_clk) disable iff (rst)
        multiply_working_by_file |-> status_out == status_in;
    endproperty
    chk_flags_on_mul: assert property (p_flags_on_mul) // [RL2]
        else $error("flags changed during multiply");

    property p_flags_after_mul;
        @(posedge sys_clk) disable iff (rst)
        multiply_working_by_file |=> status_out == status_in;
    endproperty
    chk_flags_after_mul: assert property (p_flags_after_mul) // [RL2]
        else $error("flags changed after multiply");

    ////////////////////////////////////////////////////////////////////////////
    // a same-cycle direct write must not spoil the product
    property p_collide_high;
        @(posedge sys_clk) disable iff (rst)
        multiply_working_by_file && prod_hi_write |=> product_high_byte ==
            bhm_hi_of($past(working_register), $past(file_operand));
    endproperty
    chk_collide_high: assert property (p_collide_high) // [RL3]
        else $error("direct write beat multiply on high byte");

    property p_collide_low;
        @(posedge sys_clk) disable iff (rst)
        multiply_working_by_file && prod_lo_write |=> product_low_byte ==
            bhm_lo_of($past(working_register), $past(file_operand));
    endproperty
    chk_collide_low: assert property (p_collide_low) // [RL3]
        else $error("direct write beat multiply on low byte");

    property p_back_to_back;
        @(posedge sys_clk) disable iff (rst)
        multiply_working_by_file ##1 multiply_working_by_file |=> product_low_byte ==
            bhm_lo_of($past(working_register), $past(file_operand));
    endproperty
    chk_back_to_back: assert property (p_back_to_back) // [RL3]
        else $error("second multiply in a row lost");

    property p_file_operand;
        @(posedge sys_clk) disable iff (rst)
        multiply_working_by_file && working_register == 8'h01
            |=> product_low_byte == $past(file_operand) && product_high_byte == 8'h00;
    endproperty
    chk_file_operand: assert property (p_file_operand) // [RL4]
        else $error("file register not used as operand");

    ////////////////////////////////////////////////////////////////////////////
    // direct writes touch only their own byte
    property p_low_kept;
        @(posedge sys_clk) disable iff (rst)
        prod_hi_write && !prod_lo_write && !multiply_working_by_file
            |=> $stable(product_low_byte);
    endproperty
    chk_low_kept: assert property (p_low_kept) // [RL9]
        else $error("high write disturbed low byte");

    property p_high_kept;
        @(posedge sys_clk) disable iff (rst)
        prod_lo_write && !prod_hi_write && !multiply_working_by_file
            |=> $stable(product_high_byte);
    endproperty
    chk_high_kept: assert property (p_high_kept) // [RL9]
        else $error("low write disturbed high byte");

    property p_both_written;
        @(posedge sys_clk) disable iff (rst)
        prod_hi_write && prod_lo_write && !multiply_working_by_file
            |=> product_high_byte == $past(write_data) && product_low_byte == $past(write_data);
    endproperty
    chk_both_written: assert property (p_both_written) // [RL9]
        else $error("paired direct write lost");

endmodule
`default_nettype wire

// *** tb/bhm_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bhm_core_model (
    // instruction clock
    input wire logic sys_clk,
    // product pair read back by software
    input wire logic [7:0] prod_hi,
    input wire logic [7:0] prod_lo,
    // decoded instruction fields
    output logic mul,
    output logic hw,
    output logic lw,
    output logic [7:0] w_reg,
    output logic [7:0] f_reg,
    output logic [7:0] wd
);
    initial {mul, hw, lw, w_reg, f_reg, wd} = '0;
    // one instruction a cycle; fields launched just after the edge, held a full cycle
    task automatic op(input logic m, h, l, input logic [7:0] a, b);
        @(posedge sys_clk);
        #1;
        {mul, hw, lw} = {m, h, l};
        w_reg = a;
        f_reg = b;
        wd = b;
    endtask
    // signed 8x8: unsigned multiply, then per operand a sign test and a high-byte subtract
    task automatic signed8(input logic [7:0] a, b, output logic [15:0] r, output int cyc);
        cyc = 0;
        op(1'b1, 1'b0, 1'b0, a, b);
        cyc++;
        op(1'b0, 1'b0, 1'b0, a, b);
        cyc++;
        if (b[7]) begin
            op(1'b0, 1'b1, 1'b0, a, prod_hi - a);
            cyc++;
        end
        op(1'b0, 1'b0, 1'b0, a, b);
        cyc++;
        if (a[7]) begin
            op(1'b0, 1'b1, 1'b0, a, prod_hi - b);
            cyc++;
        end
        op(1'b0, 1'b0, 1'b0, a, b);
        r = {prod_hi, prod_lo};
    endtask
    // unsigned 16x16 from four partial products, each read one cycle after its multiply
    task automatic unsigned16(input logic [15:0] a, b, output logic [31:0] res, output int cyc);
        logic [31:0] part;
        cyc = 0;
        res = 32'h0000_0000;
        for (int k = 0; k < 4; k++) begin
            op(1'b1, 1'b0, 1'b0, k[0] ? a[15:8] : a[7:0], k[1] ? b[15:8] : b[7:0]);
            op(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
            cyc += 2;
            part = {16'h0000, prod_hi, prod_lo} << (8 * (k[0] + k[1]));
            res = res + part;
        end
    endtask
    // signed 16x16: unsigned result, then sign corrections on the upper half
    task automatic signed16(input logic [15:0] a, b, output logic [31:0] res, output int cyc);
        unsigned16(a, b, res, cyc);
        op(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
        cyc++;
        if (b[15]) begin
            res[31:16] = res[31:16] - a;
            op(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
            cyc += 2;
        end
        op(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
        cyc++;
        if (a[15]) begin
            res[31:16] = res[31:16] - b;
            op(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
            cyc += 2;
        end
    endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bhm_map.svh"
module testbench;
    import bhm_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic mul, hw, lw;
    logic [4:0] st_in = 5'h00;
    logic [4:0] st_out;
    bhm_byte_t w_reg, f_reg, wd, hi, lo;
    bhm_byte_t ta[5] = '{8'h12, 8'hff, 8'h00, 8'h80, 8'h01};
    bhm_byte_t tb[5] = '{8'h34, 8'hff, 8'hff, 8'h02, 8'h01};
    int mismatches = 0;
    int checked = 0;
    always #25 sys_clk = ~sys_clk;
    bhm_core_model bhm_core_model_i (.sys_clk(sys_clk), .prod_hi(hi), .prod_lo(lo),
        .mul(mul), .hw(hw), .lw(lw),
        .w_reg(w_reg), .f_reg(f_reg), .wd(wd));
    bhm_multiplier bhm_multiplier_i (.sys_clk(sys_clk), .rst(rst),
        .multiply_working_by_file(mul), .working_register(w_reg), .file_operand(f_reg),
        .status_in(st_in), .status_out(st_out), .prod_hi_write(hw), .prod_lo_write(lw),
        .write_data(wd), .product_high_byte(hi), .product_low_byte(lo));
    task check(input bhm_prod_t seen, input bhm_prod_t exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // each step holds its fields across two edges, so every strobe is applied at two edges in a row
    task step(input logic m, h, l, input bhm_byte_t a, b);
        bhm_core_model_i.op(m, h, l, a, b);
        @(posedge sys_clk);
        #1;
    endtask
    task t_mul;
        for (int i = 0; i < 5; i++) begin
            st_in = ta[i][4:0] ^ 5'h15;
            step(1'b1, 1'b0, 1'b0, ta[i], tb[i]);
            check({hi, lo}, 16'(ta[i]) * 16'(tb[i]));
            check({11'h000, st_out}, {11'h000, st_in});
        end
        $display("multiply table done");
    endtask
    task t_write;
        step(1'b0, 1'b1, 1'b0, 8'h00, 8'h5a);
        check({hi, lo}, 16'h5a01);
        step(1'b0, 1'b0, 1'b1, 8'h00, 8'hc3);
        repeat (3) step(1'b0, 1'b0, 1'b0, 8'h77, 8'h99);
        check({hi, lo}, 16'h5ac3);
        // direct write colliding with a multiply loses
        step(1'b1, 1'b1, 1'b1, 8'h10, 8'h10);
        check({hi, lo}, 16'h0100);
        step(1'b0, 1'b1, 1'b1, 8'h00, 8'h66);
        check({hi, lo}, 16'h6666);
        $display("direct write and hold done");
    endtask
    task t_soft;
        logic [15:0] r;
        logic [31:0] r32;
        int cyc;
        bhm_core_model_i.signed8(8'hfe, 8'h05, r, cyc);
        check(r, 16'hfff6);
        check({15'h0000, cyc <= `BHM_S8_CYCLES}, 16'h0001);
        bhm_core_model_i.signed8(8'h81, 8'hff, r, cyc);
        check(r, 16'h007f);
        bhm_core_model_i.unsigned16(16'h1234, 16'h5678, r32, cyc);
        check(r32[31:16], 16'h0626);
        check(r32[15:0], 16'h0060);
        check({15'h0000, cyc <= `BHM_U16_CYCLES}, 16'h0001);
        bhm_core_model_i.unsigned16(16'hffff, 16'hffff, r32, cyc);
        check(r32[31:16], 16'hfffe);
        check(r32[15:0], 16'h0001);
        bhm_core_model_i.signed16(16'hfffe, 16'h0003, r32, cyc);
        check(r32[31:16], 16'hffff);
        check(r32[15:0], 16'hfffa);
        check({15'h0000, cyc <= `BHM_S16_CYCLES}, 16'h0001);
        $display("software sequences done");
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        #1 rst = 1'b0;
        check({hi, lo}, 16'h0000);
        t_mul();
        t_write();
        t_soft();
        wrap_up();
    end
endmodule
`default_nettype wire
